// ---- logic/cwb_pkg.sv ----
// Package of register map, field positions and timing constants for cwb.
// Operation
// RQ1: Watchdog is forced off while a fallback image is being loaded.
// RQ2: Watchdog bit 31 enables user-mode monitoring; resets to 0.
// RQ3: User-mode watchdog counts on the oscillator clock divided by 256.
// RQ4: Watchdog bit 30 enables configuration monitoring; resets to 0.
// RQ5: Config watchdog counts config clock, external clock after header read.
// RQ6: Watchdog bits 29..0 hold the time-out count; reset to zero.
// RQ7: Boot history clears only on power-on, program pin or scan reprogram.
// RQ8: At end of startup or error, current group shifts to previous, reloads.
// RQ9: Current group bits 6..0: wrap, CRC, ID, watchdog, internal, fallback, valid.
// RQ10: Previous group bits 14..8 same order; bit 7 and 31..15 reserved.
// RQ11: Wraparound error reported only in asynchronous parallel flash mode.
// RQ12: Fallback sets the fallback flag and drives revision select to 00.
// RQ13: All boot history fields power up as zero.
// RQ14: Control register 1 writes change only bits enabled in the mask.
// RQ15: Control register 1 bit 23 enables readback capture; default 0.
// RQ16: Flash options bit 27 selects synchronous parallel reads; default 0.
// RQ17: Flash options bits 26..12 hold the parallel flash read config value.
// RQ18: Flash options bit 10 selects 32-bit serial addresses; default 24-bit.
// RQ19: Flash options bits 9..8 give serial lane count; default one line.
// RQ20: Flash options bits 7..0 hold serial read instruction; reset 0x0b.
// RQ21: Enabled watchdog reaching time-out flags error and starts fallback.
package cwb_pkg;
    // Register indices; byte address is four times the index.
    localparam logic [7:0] IDX_WATCHDOG = 8'h11;
    localparam logic [7:0] IDX_BOOT_HIST = 8'h16;
    localparam logic [7:0] IDX_CTL_ONE = 8'h18;
    localparam logic [7:0] IDX_FLASH_OPT = 8'h1f;
    localparam logic [7:0] IDX_MASK = 8'h20;
    localparam logic [7:0] IDX_STATUS = 8'h21;
    localparam int ADDR_LSB = 2;
    // Watchdog fields.
    localparam int WD_USER_BIT = 31;
    localparam int WD_CFG_BIT = 30;
    localparam int WD_VAL_W = 30;
    localparam logic [31:0] WD_RESET = 32'h0000_0000;
    localparam int WD_DIV = 256;
    // Boot history fields within one group.
    localparam int BH_WRAP = 6;
    localparam int BH_CRC = 5;
    localparam int BH_ID = 4;
    localparam int BH_WDOG = 3;
    localparam int BH_IPROG = 2;
    localparam int BH_FALLBACK = 1;
    localparam int BH_VALID = 0;
    localparam int BH_PREV_LSB = 8;
    localparam int BH_GRP_W = 7;
    // Control register 1.
    localparam int CTL_CAPTURE_BIT = 23;
    localparam logic [31:0] CTL_RESET = 32'h0000_0000;
    localparam logic [31:0] MASK_RESET = 32'h0000_0000;
    // Flash options fields.
    localparam int FO_SYNC_BIT = 27;
    localparam int FO_RCR_MSB = 26;
    localparam int FO_RCR_LSB = 12;
    localparam int FO_WIDE_BIT = 10;
    localparam int FO_LANE_MSB = 9;
    localparam int FO_LANE_LSB = 8;
    localparam int FO_INSTR_MSB = 7;
    localparam logic [31:0] FO_RESET = 32'h0000_000b;
    localparam logic [31:0] FO_WMASK = 32'h0fff_f7ff;
    localparam logic [1:0] RS_FALLBACK = 2'h0;
endpackage

// ---- logic/cwb_div.sv ----
// Clock-enable divider that produces the user-mode watchdog tick.
`timescale 1ns/100ps
module cwb_div (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ce,
    // Oscillator tick in, divided tick out.
    input wire logic osc_tick,
    output logic div_tick
);
    typedef struct packed {
        logic [7:0] cnt;
        logic tick;
    } cwb_div_s;
    cwb_div_s s_q;
    cwb_div_s s_d;

    // Count oscillator ticks and pulse once every 256 of them.
    always_comb begin
        s_d = s_q;
        s_d.tick = 1'b0;
        if (osc_tick) begin
            s_d.cnt = s_q.cnt + 8'h01; // RQ3
            s_d.tick = (s_q.cnt == 8'(cwb_pkg::WD_DIV - 1));
        end
    end

    // Register the divider state.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s_q <= '0;
        end else if (ce) begin
            s_q <= s_d;
        end
    end

    assign div_tick = s_q.tick;
endmodule // cwb_div

// ---- logic/cwb_regs.sv ----
// Watchdog, boot history, masked control and flash option registers.
//
// Design decision made here: the Wishbone interface to the registers.
`timescale 1ns/100ps
module cwb_regs (
    // Clock, reset and freeze.
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ce,
    // Wishbone slave.
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // Boot history clear sources.
    input wire logic program_pin,
    input wire logic scan_reprogram_instruction,
    // Configuration progress and error events.
    input wire logic user_mode,
    input wire logic fallback_image,
    input wire logic end_of_startup,
    input wire logic crc_err,
    input wire logic cur_id_err,
    input wire logic wrap_err,
    input wire logic cur_internal_reprogram,
    // Watchdog clock ticks.
    input wire logic configuration_clock,
    input wire logic external_config_clock,
    input wire logic use_external_clock,
    input wire logic header_read,
    input wire logic internal_config_osc_clock,
    // Outputs to configuration logic.
    output logic wd_timeout,
    output logic fallback_start,
    output logic [1:0] revision_select_out,
    output logic revision_select_oe,
    output logic readback_capture_en,
    output logic pflash_sync_read_sel,
    output logic [14:0] pflash_read_cfg_value,
    output logic sflash_wide_addr_sel,
    output logic [1:0] sflash_lane_count,
    output logic [7:0] sflash_read_instr
);
    typedef struct packed {
        logic [31:0] wd;
        logic [29:0] wd_cnt;
        logic [6:0] cur;
        logic [6:0] prev;
        logic [31:0] ctl;
        logic [31:0] mask;
        logic [31:0] fo;
        logic fallback_active;
        logic [31:0] rdata;
        logic ack;
        logic tmo;
    } cwb_regs_s;
    cwb_regs_s s_q;
    cwb_regs_s s_d;
    logic div_tick;

    // Byte-lane merge used by every writable register.
    function automatic logic [31:0] lane_merge(input logic [31:0] old,
            input logic [31:0] nw, input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    cwb_div u_div (
        .clk(clk),
        .rst_b(rst_b),
        .ce(ce),
        .osc_tick(internal_config_osc_clock),
        .div_tick(div_tick)
    );

    logic wb_hit;
    logic wr;
    logic [7:0] idx;
    logic wd_on;
    logic wd_tick;
    logic bh_event;
    logic [6:0] new_stat;
    logic [31:0] ctl_w;
    assign wb_hit = cyc_i && stb_i && !s_q.ack;
    assign wr = wb_hit && we_i;
    assign idx = {2'h0, adr_i[7:cwb_pkg::ADDR_LSB]};

    // Watchdog runs only in the enabled phase and never for fallback images.
    always_comb begin
        wd_on = (user_mode ? s_q.wd[cwb_pkg::WD_USER_BIT] // RQ2
                           : s_q.wd[cwb_pkg::WD_CFG_BIT]) // RQ4
                && !fallback_image; // RQ1
        if (user_mode) begin
            wd_tick = div_tick; // RQ3
        end else if (use_external_clock && header_read) begin
            wd_tick = external_config_clock; // RQ5
        end else begin
            wd_tick = configuration_clock; // RQ5
        end
    end

    // Events that shift the boot history and the status loaded with them.
    always_comb begin
        bh_event = end_of_startup || crc_err || cur_id_err || s_q.tmo
                   || (wrap_err && !s_q.fo[cwb_pkg::FO_SYNC_BIT]);
        new_stat = '0;
        new_stat[cwb_pkg::BH_WRAP] = wrap_err
            && !s_q.fo[cwb_pkg::FO_SYNC_BIT]; // RQ11
        new_stat[cwb_pkg::BH_CRC] = crc_err; // RQ9
        new_stat[cwb_pkg::BH_ID] = cur_id_err;
        new_stat[cwb_pkg::BH_WDOG] = s_q.tmo; // RQ21
        new_stat[cwb_pkg::BH_IPROG] = cur_internal_reprogram;
        new_stat[cwb_pkg::BH_FALLBACK] = fallback_image; // RQ12
        new_stat[cwb_pkg::BH_VALID] = end_of_startup;
        ctl_w = lane_merge(s_q.ctl, dat_i, sel_i);
    end

    // Next-state logic for registers, counter and bus answer.
    always_comb begin
        s_d = s_q;
        s_d.ack = wb_hit;
        s_d.tmo = 1'b0;
        // Counter restarts whenever the watchdog is not armed.
        if (!wd_on) begin
            s_d.wd_cnt = '0;
        end else if (wd_tick) begin
            if (s_q.wd_cnt == s_q.wd[cwb_pkg::WD_VAL_W-1:0]) begin
                s_d.tmo = 1'b1; // RQ21
                s_d.wd_cnt = '0;
            end else begin
                s_d.wd_cnt = s_q.wd_cnt + 30'h1;
            end
        end
        if (bh_event) begin
            s_d.prev = s_q.cur; // RQ8
            s_d.cur = new_stat; // RQ8
        end
        if (s_q.tmo) begin
            s_d.fallback_active = 1'b1; // RQ12
        end
        // Clearing sources besides power-on reset; events only shift history, bus writes never touch it.
        if (program_pin || scan_reprogram_instruction) begin
            s_d.cur = '0; // RQ7
            s_d.prev = '0; // RQ7
            s_d.fallback_active = 1'b0;
        end
        if (wr) begin
            unique case (idx)
                cwb_pkg::IDX_WATCHDOG:
                    s_d.wd = lane_merge(s_q.wd, dat_i, sel_i); // RQ6
                cwb_pkg::IDX_CTL_ONE:
                    s_d.ctl = (s_q.ctl & ~s_q.mask)
                              | (ctl_w & s_q.mask); // RQ14
                cwb_pkg::IDX_MASK:
                    s_d.mask = lane_merge(s_q.mask, dat_i, sel_i);
                cwb_pkg::IDX_FLASH_OPT:
                    s_d.fo = lane_merge(s_q.fo, dat_i, sel_i)
                             & cwb_pkg::FO_WMASK; // RQ20
                default: begin
                end
            endcase
        end
        // Reads answer from a register; unmapped addresses read zero.
        s_d.rdata = '0;
        if (wb_hit && !we_i) begin
            unique case (idx)
                cwb_pkg::IDX_WATCHDOG: s_d.rdata = s_q.wd;
                cwb_pkg::IDX_BOOT_HIST:
                    s_d.rdata = {17'h0, s_q.prev, 1'b0, s_q.cur}; // RQ10
                cwb_pkg::IDX_CTL_ONE:
                    s_d.rdata = {8'h0, s_q.ctl[cwb_pkg::CTL_CAPTURE_BIT],
                                 23'h0}; // RQ15
                cwb_pkg::IDX_MASK: s_d.rdata = s_q.mask;
                cwb_pkg::IDX_FLASH_OPT: s_d.rdata = s_q.fo;
                cwb_pkg::IDX_STATUS:
                    s_d.rdata = {2'h0, s_q.wd_cnt};
                default: s_d.rdata = '0;
            endcase
        end
    end

    // State register; power-on reset zeroes history and loads defaults.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s_q <= '0; // RQ13
            s_q.wd <= cwb_pkg::WD_RESET;
            s_q.ctl <= cwb_pkg::CTL_RESET;
            s_q.mask <= cwb_pkg::MASK_RESET;
            s_q.fo <= cwb_pkg::FO_RESET; // RQ20
        end else if (ce) begin
            s_q <= s_d;
        end
    end

    // Outputs decoded from the register copies.
    assign dat_o = s_q.rdata;
    assign ack_o = s_q.ack;
    assign wd_timeout = s_q.tmo;
    assign fallback_start = s_q.tmo; // RQ21
    assign revision_select_out = cwb_pkg::RS_FALLBACK; // RQ12
    assign revision_select_oe = s_q.fallback_active; // RQ12
    assign readback_capture_en = s_q.ctl[cwb_pkg::CTL_CAPTURE_BIT]; // RQ15
    assign pflash_sync_read_sel = s_q.fo[cwb_pkg::FO_SYNC_BIT]; // RQ16
    assign pflash_read_cfg_value =
        s_q.fo[cwb_pkg::FO_RCR_MSB:cwb_pkg::FO_RCR_LSB]; // RQ17
    assign sflash_wide_addr_sel = s_q.fo[cwb_pkg::FO_WIDE_BIT]; // RQ18
    assign sflash_lane_count =
        s_q.fo[cwb_pkg::FO_LANE_MSB:cwb_pkg::FO_LANE_LSB]; // RQ19
    assign sflash_read_instr = s_q.fo[cwb_pkg::FO_INSTR_MSB:0]; // RQ20

    // Timeout must be followed by the watchdog flag in the history.
    wd_flag_set_a: assert property (@(posedge clk) disable iff (!rst_b) // RQ21
        ce && s_q.tmo && !program_pin && !scan_reprogram_instruction
        |=> s_q.cur[cwb_pkg::BH_WDOG])
        else $error("watchdog timeout not recorded");
    // Fallback image keeps the counter parked.
    wd_fallback_off_a: assert property (@(posedge clk) disable iff (!rst_b)
        ce && fallback_image |=> s_q.wd_cnt == '0) // RQ1
        else $error("watchdog ran during fallback");
    // History shift moves current into previous.
    bh_shift_a: assert property (@(posedge clk) disable iff (!rst_b) // RQ8
        ce && bh_event && !program_pin && !scan_reprogram_instruction
        |=> s_q.prev == $past(s_q.cur))
        else $error("boot history did not shift");
    // Program clears both groups.
    bh_clear_a: assert property (@(posedge clk) disable iff (!rst_b) // RQ7
        ce && program_pin |=> s_q.cur == '0 && s_q.prev == '0)
        else $error("boot history not cleared");
    // Wrap error never recorded in synchronous mode.
    wrap_sync_a: assert property (@(posedge clk) disable iff (!rst_b) // RQ11
        ce && s_q.fo[cwb_pkg::FO_SYNC_BIT] && bh_event
        |=> !s_q.cur[cwb_pkg::BH_WRAP])
        else $error("wrap error in sync mode");
    // Masked-off bits of control register 1 hold.
    ctl_mask_a: assert property (@(posedge clk) disable iff (!rst_b) // RQ14
        ce && wr && idx == cwb_pkg::IDX_CTL_ONE
        |=> ((s_q.ctl ^ $past(s_q.ctl)) & $past(s_q.mask)) ==
            (s_q.ctl ^ $past(s_q.ctl)))
        else $error("masked control bit changed");
    // Every request is acknowledged the next cycle for one cycle.
    bus_ack_a: assert property (@(posedge clk) disable iff (!rst_b)
        ce && wb_hit |=> ack_o ##1 !ack_o || !ce)
        else $error("bus ack timing wrong");
    // Revision select is driven after a fallback starts.
    rs_drive_a: assert property (@(posedge clk) disable iff (!rst_b) // RQ12
        ce && s_q.tmo && !program_pin && !scan_reprogram_instruction
        |=> revision_select_oe && revision_select_out == 2'h0)
        else $error("revision select not driven");
endmodule // cwb_regs

// ---- testbench/cwb_host.sv ----
// Wishbone classic host model issuing one register cycle per start pulse.
`timescale 1ns/100ps
module cwb_host (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_b,
    // Request from the bench.
    input wire logic start,
    input wire logic we,
    input wire logic [7:0] adr,
    input wire logic [31:0] wdat,
    output logic done,
    output logic [31:0] rdat,
    // Wishbone master side.
    output logic cyc_o,
    output logic stb_o,
    output logic we_o,
    output logic [7:0] adr_o,
    output logic [3:0] sel_o,
    output logic [31:0] dat_o,
    input wire logic ack_i,
    input wire logic [31:0] dat_i
);
    // Request holds until ack; released lines carry inverted data.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            {cyc_o, stb_o, we_o, done} <= 4'h0;
            adr_o <= 8'h00;
            sel_o <= 4'h0;
            dat_o <= 32'h0;
            rdat <= 32'h0;
        end else begin
            done <= 1'b0;
            if (cyc_o && ack_i) begin
                {cyc_o, stb_o} <= 2'h0;
                rdat <= dat_i;
                adr_o <= ~adr_o;
                dat_o <= ~dat_o;
                done <= 1'b1;
            end else if (start && !cyc_o) begin
                {cyc_o, stb_o, we_o} <= {2'h3, we};
                adr_o <= adr;
                sel_o <= 4'hf;
                dat_o <= wdat;
            end
        end
    end
endmodule // cwb_host

// ---- testbench/config_watchdog_bootstatus_regs_tb.sv ----
// Self-checking bench for the watchdog and boot status register bank.
`timescale 1ns/100ps
module config_watchdog_bootstatus_regs_tb;
    logic clk, rst_b, h_start, h_we, h_done, cyc, stb, we, ack;
    logic [7:0] h_adr, adr;
    logic [3:0] sel;
    logic [31:0] h_wdat, h_rdat, wdat, rdat, v, m, r, fo_out;
    logic [1:0] clr, rs, lanes;
    logic [4:0] ev;
    logic [2:0] tk;
    logic user_mode, fb_img, use_ext, hdr, wd_to, fb_st, rs_oe, cap, cap_exp;
    logic psync, wide, ce_en;
    logic [14:0] rcr;
    logic [7:0] instr;
    int n_errors, n_tests, seed, i, n;
    assign fo_out = {4'h0, psync, rcr, 1'b0, wide, lanes, instr};
    cwb_host u_cwb_host (.clk(clk), .rst_b(rst_b), .start(h_start),
        .we(h_we), .adr(h_adr), .wdat(h_wdat), .done(h_done), .rdat(h_rdat),
        .cyc_o(cyc), .stb_o(stb), .we_o(we), .adr_o(adr), .sel_o(sel),
        .dat_o(wdat), .ack_i(ack), .dat_i(rdat));
    cwb_regs u_cwb_regs (.clk(clk), .rst_b(rst_b), .ce(ce_en), .cyc_i(cyc),
        .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat),
        .dat_o(rdat), .ack_o(ack), .program_pin(clr[0]),
        .scan_reprogram_instruction(clr[1]), .user_mode(user_mode),
        .fallback_image(fb_img), .end_of_startup(ev[4]), .crc_err(ev[3]),
        .cur_id_err(ev[2]), .wrap_err(ev[1]), .cur_internal_reprogram(ev[0]),
        .configuration_clock(tk[0]), .external_config_clock(tk[1]),
        .use_external_clock(use_ext), .header_read(hdr),
        .internal_config_osc_clock(tk[2]), .wd_timeout(wd_to),
        .fallback_start(fb_st), .revision_select_out(rs),
        .revision_select_oe(rs_oe), .readback_capture_en(cap),
        .pflash_sync_read_sel(psync), .pflash_read_cfg_value(rcr),
        .sflash_wide_addr_sel(wide), .sflash_lane_count(lanes),
        .sflash_read_instr(instr));
    // Free-running 100 MHz clock.
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Prints the counts and the verdict, then ends the run.
    task summarize();
        $display("tests=%0d errors=%0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // Compares one 32-bit result against its expectation.
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One bus cycle through the host model; read data lands in r.
    task bus(input logic w, input logic [7:0] x, input logic [31:0] d);
        int k;
        @(posedge clk);
        h_we <= w;
        h_adr <= {x[5:0], 2'b00};
        h_wdat <= d;
        h_start <= 1'b1;
        @(posedge clk);
        h_start <= 1'b0;
        for (k = 0; k < 50 && h_done !== 1'b1; k++) @(negedge clk);
        if (k == 50) begin
            n_errors++;
            summarize();
        end
        r = h_rdat;
    endtask
    // Pulses status events for one cycle, then reads the boot history.
    task evt(input logic [4:0] e5);
        @(posedge clk);
        ev <= e5;
        @(posedge clk);
        ev <= 5'h0;
        repeat (3) @(posedge clk);
        bus(1'b0, cwb_pkg::IDX_BOOT_HIST, 32'h0);
    endtask
    // Sets the tick sources, then counts cycles until a time-out pulse.
    task wdw(input logic [2:0] t, input int lim);
        @(posedge clk);
        tk <= t;
        n = 0;
        while (n < lim && wd_to !== 1'b1) begin
            @(negedge clk);
            n++;
        end
    endtask
    // Main sequence; a timed-out wait ends in the same report.
    initial begin
        {rst_b, h_start, h_we, clr, ev, tk} = '0;
        {user_mode, fb_img, use_ext, hdr} = 4'h0;
        ce_en = 1'b1;
        h_adr = 8'h00;
        h_wdat = 32'h0;
        seed = 65369;
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        bus(1'b0, cwb_pkg::IDX_WATCHDOG, 32'h0);
        chk(r, cwb_pkg::WD_RESET);
        evt(5'h0);
        chk(r, 32'h0);
        bus(1'b0, cwb_pkg::IDX_FLASH_OPT, 32'h0);
        chk(r, cwb_pkg::FO_RESET);
        @(negedge clk);
        chk(fo_out, cwb_pkg::FO_RESET);
        chk({30'h0, cap, rs_oe}, 32'h0);
        v = $random(seed);
        bus(1'b1, cwb_pkg::IDX_WATCHDOG, v);
        bus(1'b0, cwb_pkg::IDX_WATCHDOG, 32'h0);
        chk(r, v);
        bus(1'b1, 8'h05, v);
        bus(1'b0, 8'h05, 32'h0);
        chk(r, 32'h0);
        // Every lane-count code, with random other fields.
        for (i = 0; i < 4; i++) begin
            v = $random(seed);
            v[9:8] = i[1:0];
            bus(1'b1, cwb_pkg::IDX_FLASH_OPT, v);
            bus(1'b0, cwb_pkg::IDX_FLASH_OPT, 32'h0);
            chk(r, v & cwb_pkg::FO_WMASK);
            chk(fo_out, v & cwb_pkg::FO_WMASK);
        end
        // Masked writes; the first one tries to set capture while masked.
        cap_exp = 1'b0;
        for (i = 0; i < 6; i++) begin
            m = $random(seed);
            v = $random(seed);
            if (i == 0) begin
                m[23] = 1'b0;
                v[23] = 1'b1;
            end
            if (m[23]) cap_exp = v[23];
            bus(1'b1, cwb_pkg::IDX_MASK, m);
            bus(1'b1, cwb_pkg::IDX_CTL_ONE, v);
            bus(1'b0, cwb_pkg::IDX_CTL_ONE, 32'h0);
            chk(r, {8'h0, cap_exp, 23'h0});
            chk({31'h0, cap}, {31'h0, cap_exp});
        end
        bus(1'b1, cwb_pkg::IDX_FLASH_OPT, 32'h0);
        evt(5'h10);
        chk(r, 32'h1);
        bus(1'b1, cwb_pkg::IDX_BOOT_HIST, 32'hffff_ffff);
        evt(5'h0);
        chk(r, 32'h1);
        evt(5'h08);
        chk(r & 32'h7f20, 32'h0120);
        evt(5'h04);
        chk(r & 32'h2010, 32'h2010);
        // Internal reprogram is captured with the end-of-startup event.
        evt(5'h11);
        chk(r & 32'h1004, 32'h1004);
        evt(5'h02);
        chk(r & 32'h0440, 32'h0440);
        // Both clear sources wipe both groups.
        for (i = 0; i < 2; i++) begin
            evt(5'h10);
            @(posedge clk);
            clr[i] <= 1'b1;
            @(posedge clk);
            clr[i] <= 1'b0;
            evt(5'h0);
            chk(r, 32'h0);
        end
        bus(1'b1, cwb_pkg::IDX_FLASH_OPT, 32'h0800_0000);
        // A real event shifts history, but the wrap flag stays clear.
        evt(5'h12);
        chk(r & 32'h41, 32'h1);
        // Configuration watchdog held off while a fallback image loads.
        @(posedge clk) fb_img <= 1'b1;
        bus(1'b1, cwb_pkg::IDX_WATCHDOG, 32'h4000_0003);
        wdw(3'b001, 40);
        chk(32'(n), 32'd40);
        // An event while the fallback image loads records the fallback flag.
        evt(5'h10);
        chk(r & 32'h3, 32'h3);
        @(posedge clk) fb_img <= 1'b0;
        wdw(3'b001, 40);
        chk({31'h0, n < 40}, 32'h1);
        chk({30'h0, wd_to, fb_st}, 32'h3);
        @(posedge clk) tk <= 3'b000;
        evt(5'h0);
        chk(r & 32'h8, 32'h8);
        chk({29'h0, rs_oe, rs}, 32'h4);
        // External ticks count only once the header has been read.
        @(posedge clk) use_ext <= 1'b1;
        bus(1'b1, cwb_pkg::IDX_WATCHDOG, 32'h4000_0002);
        wdw(3'b010, 20);
        chk(32'(n), 32'd20);
        @(posedge clk) hdr <= 1'b1;
        wdw(3'b010, 40);
        chk({31'h0, n < 40}, 32'h1);
        @(posedge clk) tk <= 3'b000;
        // A frozen block must ignore a status event pulsed meanwhile.
        bus(1'b0, cwb_pkg::IDX_BOOT_HIST, 32'h0);
        v = r;
        @(posedge clk);
        ce_en <= 1'b0;
        ev <= 5'h10;
        @(posedge clk);
        ce_en <= 1'b1;
        ev <= 5'h0;
        bus(1'b0, cwb_pkg::IDX_BOOT_HIST, 32'h0);
        chk(r, v);
        // User mode counts the oscillator divided by 256.
        @(posedge clk) user_mode <= 1'b1;
        bus(1'b1, cwb_pkg::IDX_WATCHDOG, 32'h8000_0000);
        wdw(3'b100, 400);
        chk({31'h0, n >= 250 && n <= 265}, 32'h1);
        summarize();
    end
endmodule // config_watchdog_bootstatus_regs_tb
